// *** msm_pkg.sv ***
// package of the muting sequence monitor: register map, reset values, timing
// constants and the packed carriers shared by the top and the pair conditioner.
// assumes a 250 MHz pclk and a 1 ms scan of the muting logic.
package msm_pkg;

    // clock and scan timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCAN_PERIOD_NS = 1000000;
    localparam int SCAN_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SCAN_MS = 1;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TOTAL = 8'h04;
    localparam logic [7:0] ADDR_EXTRA = 8'h08;
    localparam logic [7:0] ADDR_CONC = 8'h0c;
    localparam logic [7:0] ADDR_GAP = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_INT_STAT = 8'h18;
    localparam logic [7:0] ADDR_INT_MASK = 8'h1c;
    localparam logic [7:0] ADDR_CMD = 8'h20;

    // ctrl and cmd field positions
    localparam int CTRL_DIR_LSB = 0;
    localparam int CTRL_START_LAST_BIT = 2;
    localparam int CTRL_END_PROTECTIVE_SWITCHING_OUTPUT_BIT = 3;
    localparam int CTRL_AUX_BIT = 4;
    localparam int CTRL_OVR_BIT = 5;
    localparam int CTRL_CONV_BIT = 6;
    localparam int CMD_CLEAR_BIT = 0;

    // reset values
    localparam logic [6:0] CTRL_RESET = 7'h74;
    localparam logic [11:0] TOTAL_RESET = 12'h005;
    localparam logic [1:0] EXTRA_RESET = 2'h0;
    localparam logic [8:0] CONC_RESET = 9'h000;
    localparam logic [6:0] GAP_RESET = 7'h0a;

    // configuration limits, in the register units (s, 10 ms)
    localparam logic [11:0] TOTAL_MIN_S = 12'd5;
    localparam logic [11:0] TOTAL_MAX_S = 12'd3600;
    localparam logic [8:0] CONC_MAX_10MS = 9'd300;
    localparam logic [6:0] GAP_MAX_10MS = 7'd100;
    localparam int MS_PER_S = 1000;
    localparam int MS_PER_STEP = 10;

    // extra muting time choices
    localparam int EXTRA_MS_0 = 0;
    localparam int EXTRA_MS_1 = 200;
    localparam int EXTRA_MS_2 = 500;
    localparam int EXTRA_MS_3 = 1000;

    // interrupt status bits
    localparam int IRQ_MUTE_START = 0;
    localparam int IRQ_MUTE_END = 1;
    localparam int IRQ_MUTE_ERR = 2;
    localparam int IRQ_TIMEOUT = 3;

    typedef enum logic [1:0] {
        MSM_DIR_OFF,
        MSM_DIR_FWD,
        MSM_DIR_BWD,
        MSM_DIR_RSVD
    } msm_dir_t;

    typedef struct packed {
        logic conv_present;
        logic ovr_present;
        logic aux_present;
        logic end_on_protective_switching_output;
        logic start_last;
        msm_dir_t dir;
    } msm_ctrl_t;

    typedef struct packed {
        logic both;
        logic any;
        logic gap;
        logic conc_err;
    } msm_pair_t;

endpackage

// *** msm_pair.sv ***
// one muting sensor pair: input synchronisers, gap filter and concurrency check.
// assumes tick is a one-cycle pulse once per scan and the counts are already in scans.
`timescale 1ns/1ps
module msm_pair (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic [1:0] sensor_pin,
    input wire logic [9:0] gap_scans,
    input wire logic [11:0] conc_scans,
    output msm_pkg::msm_pair_t state
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] filt_q;
    logic [9:0] gap_cnt_q [2];
    logic [11:0] conc_cnt_q;
    logic conc_done_q;
    logic conc_err_q;
    logic [1:0] in_gap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end else begin
            meta_q <= sensor_pin;
            sync_q <= meta_q;
        end
    end

    assign in_gap = filt_q & ~sync_q;

    // a short low is held high, but only for one sensor of the pair at a time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q <= 2'h0;
            gap_cnt_q[0] <= 10'h000;
            gap_cnt_q[1] <= 10'h000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (sync_q[i]) begin
                    filt_q[i] <= 1'b1;
                    gap_cnt_q[i] <= 10'h000;
                end else if (!filt_q[i]) begin
                    gap_cnt_q[i] <= 10'h000;
                end else if (gap_scans == 10'h000 || in_gap[1-i] || gap_cnt_q[i] >= gap_scans) begin
                    filt_q[i] <= 1'b0;
                end else if (tick) begin
                    gap_cnt_q[i] <= gap_cnt_q[i] + 10'h001;
                end
            end
        end
    end

    // mismatch counted from the first change; one error pulse per mismatch episode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conc_cnt_q <= 12'h000;
            conc_done_q <= 1'b0;
            conc_err_q <= 1'b0;
        end else begin
            conc_err_q <= 1'b0;
            if (sync_q[0] == sync_q[1]) begin
                conc_cnt_q <= 12'h000;
                conc_done_q <= 1'b0;
            end else if (conc_scans != 12'h000 && !conc_done_q) begin
                if (conc_cnt_q >= conc_scans) begin
                    conc_err_q <= 1'b1;
                    conc_done_q <= 1'b1;
                end else if (tick) begin
                    conc_cnt_q <= conc_cnt_q + 12'h001;
                end
            end
        end
    end

    assign state = {&filt_q, |filt_q, |in_gap, conc_err_q};

endmodule

// *** msm_top.sv ***
// muting sequence monitor: apb register file, scan divider, sequence state machine,
// total and extra muting timers, error latch and interrupt.
// assumes all sensor, curtain, override and conveyor inputs are asynchronous pins.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - forward direction accepts only first pair before second; disabled accepts either order.
// - backward direction accepts only second pair before first.
// - start condition selects all sensors inactive or last sensor still active; default last.
// - end condition selects last sensor low or switching output high; default sensor.
// - total muting limit inactive or 5 to 3600 s in 1 s steps; default 5 s.
// - extra muting time is 0, 200, 500 or 1000 ms; default 0.
// - concurrency time inactive or 10 to 3000 ms in 10 ms steps; default inactive.
// - gap filter inactive or 10 to 1000 ms in 10 ms steps; default 100 ms.
// - total time exceeded raises muting error and fault, drops output enable; checked in ST_MUTE only, not during extra muting time.
// - total timer runs while muting, clears at end, holds while conveyor stopped.
// - one-sensor short gaps read high; simultaneous gap on another signal stops muting.
// - pair not equivalent within concurrency time after first change raises muting error.
module msm_top #(
    parameter int SCAN_CYCLES = msm_pkg::SCAN_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_pair_sensor_one,
    input wire logic first_pair_sensor_two,
    input wire logic second_pair_sensor_one,
    input wire logic second_pair_sensor_two,
    input wire logic auxiliary_muting_signal,
    input wire logic protective_switching_output,
    input wire logic override_in,
    input wire logic conveyor_stopped,
    output logic muting_active,
    output logic override_active,
    output logic output_enable,
    output logic muting_error,
    output logic fault_present,
    output logic irq
);
    typedef enum {
        ST_WAIT_START,
        ST_READY,
        ST_MUTE,
        ST_EXTRA,
        ST_ERROR
    } msm_state_t;

    msm_pkg::msm_ctrl_t ctrl_q;
    logic [11:0] total_s_q;
    logic [1:0] extra_sel_q;
    logic [8:0] conc_q;
    logic [6:0] gap_q;
    logic [3:0] int_stat_q;
    logic [3:0] int_mask_q;
    logic clear_req;
    logic [3:0] meta_q;
    logic [3:0] pin_q;
    logic aux_s;
    logic protective_switching_output_s;
    logic ovr_s;
    logic conv_s;
    logic [31:0] div_q;
    logic tick;
    msm_pkg::msm_pair_t pair_a;
    msm_pkg::msm_pair_t pair_b;
    logic [9:0] gap_scans;
    logic [11:0] conc_scans;
    logic [21:0] total_scans;
    logic [9:0] extra_scans;
    msm_state_t state_q;
    logic first_is_b_q;
    logic second_seen_q;
    logic last_is_b_q;
    logic [21:0] total_cnt_q;
    logic [9:0] extra_cnt_q;
    logic error_q;
    logic fault_q;
    logic timeout;
    logic mute_start;
    logic mute_end;
    msm_pkg::msm_pair_t first_p;
    msm_pkg::msm_pair_t second_p;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [3:0] events;

    // apb: zero wait states; read data is registered in the setup cycle so it stands at the access edge
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = paddr == msm_pkg::ADDR_CTRL || paddr == msm_pkg::ADDR_TOTAL
        || paddr == msm_pkg::ADDR_EXTRA || paddr == msm_pkg::ADDR_CONC
        || paddr == msm_pkg::ADDR_GAP || paddr == msm_pkg::ADDR_STATUS
        || paddr == msm_pkg::ADDR_INT_STAT || paddr == msm_pkg::ADDR_INT_MASK
        || paddr == msm_pkg::ADDR_CMD;
    assign pslverr = psel && penable && !addr_ok;
    assign clear_req = wr_en && paddr == msm_pkg::ADDR_CMD && pstrb[0] && pwdata[msm_pkg::CMD_CLEAR_BIT];

    // configuration registers; out-of-range values clamp into the legal range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= msm_pkg::CTRL_RESET;
            total_s_q <= msm_pkg::TOTAL_RESET;
            extra_sel_q <= msm_pkg::EXTRA_RESET;
            conc_q <= msm_pkg::CONC_RESET;
            gap_q <= msm_pkg::GAP_RESET;
            int_mask_q <= 4'h0;
        end else if (wr_en && pstrb[0]) begin
            if (paddr == msm_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata[6:0];
            end else if (paddr == msm_pkg::ADDR_TOTAL && pstrb[1]) begin
                if (pwdata[11:0] == 12'h000) begin
                    total_s_q <= 12'h000;
                end else if (pwdata[11:0] < msm_pkg::TOTAL_MIN_S) begin
                    total_s_q <= msm_pkg::TOTAL_MIN_S;
                end else if (pwdata[11:0] > msm_pkg::TOTAL_MAX_S) begin
                    total_s_q <= msm_pkg::TOTAL_MAX_S;
                end else begin
                    total_s_q <= pwdata[11:0];
                end
            end else if (paddr == msm_pkg::ADDR_EXTRA) begin
                extra_sel_q <= pwdata[1:0];
            end else if (paddr == msm_pkg::ADDR_CONC && pstrb[1]) begin
                conc_q <= (pwdata[8:0] > msm_pkg::CONC_MAX_10MS) ? msm_pkg::CONC_MAX_10MS : pwdata[8:0];
            end else if (paddr == msm_pkg::ADDR_GAP) begin
                gap_q <= (pwdata[6:0] > msm_pkg::GAP_MAX_10MS) ? msm_pkg::GAP_MAX_10MS : pwdata[6:0];
            end else if (paddr == msm_pkg::ADDR_INT_MASK) begin
                int_mask_q <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (paddr == msm_pkg::ADDR_CTRL) begin
                prdata <= {25'h0, ctrl_q};
            end else if (paddr == msm_pkg::ADDR_TOTAL) begin
                prdata <= {20'h0, total_s_q};
            end else if (paddr == msm_pkg::ADDR_EXTRA) begin
                prdata <= {30'h0, extra_sel_q};
            end else if (paddr == msm_pkg::ADDR_CONC) begin
                prdata <= {23'h0, conc_q};
            end else if (paddr == msm_pkg::ADDR_GAP) begin
                prdata <= {25'h0, gap_q};
            end else if (paddr == msm_pkg::ADDR_STATUS) begin
                prdata <= {24'h0, pair_b.both, pair_a.both, protective_switching_output_s, override_active, fault_q, error_q,
                    output_enable, muting_active};
            end else if (paddr == msm_pkg::ADDR_INT_STAT) begin
                prdata <= {28'h0, int_stat_q};
            end else if (paddr == msm_pkg::ADDR_INT_MASK) begin
                prdata <= {28'h0, int_mask_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // sticky events, write one to clear; a new event in the clearing cycle survives
    assign events = {timeout, clear_req ? 1'b0 : (state_q != ST_ERROR && first_p.conc_err | second_p.conc_err),
        mute_end, mute_start};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= 4'h0;
        end else if (wr_en && pstrb[0] && paddr == msm_pkg::ADDR_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~pwdata[3:0]) | events;
        end else begin
            int_stat_q <= int_stat_q | events;
        end
    end
    assign irq = |(int_stat_q & int_mask_q);

    // pin synchronisers for the single inputs; sensors sync inside the pair modules
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 4'h0;
            pin_q <= 4'h0;
        end else begin
            meta_q <= {conveyor_stopped, override_in, protective_switching_output, auxiliary_muting_signal};
            pin_q <= meta_q;
        end
    end
    assign aux_s = pin_q[0] || !ctrl_q.aux_present;
    assign protective_switching_output_s = pin_q[1];
    assign ovr_s = pin_q[2] && ctrl_q.ovr_present;
    assign conv_s = pin_q[3] && ctrl_q.conv_present;

    // scan divider: every duration below is counted in these ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 32'h0000_0000;
        end else if (div_q >= 32'(SCAN_CYCLES - 1)) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= div_q + 32'h0000_0001;
        end
    end
    assign tick = div_q == 32'h0000_0000;

    // durations to scans, rounded up
    localparam int RND = msm_pkg::SCAN_MS - 1;
    assign gap_scans = 10'((32'(gap_q) * msm_pkg::MS_PER_STEP + RND) / msm_pkg::SCAN_MS);
    assign conc_scans = 12'((32'(conc_q) * msm_pkg::MS_PER_STEP + RND) / msm_pkg::SCAN_MS);
    assign total_scans = 22'((32'(total_s_q) * msm_pkg::MS_PER_S + RND) / msm_pkg::SCAN_MS);
    always_comb begin
        case (extra_sel_q)
            2'h0: extra_scans = 10'((msm_pkg::EXTRA_MS_0 + RND) / msm_pkg::SCAN_MS);
            2'h1: extra_scans = 10'((msm_pkg::EXTRA_MS_1 + RND) / msm_pkg::SCAN_MS);
            2'h2: extra_scans = 10'((msm_pkg::EXTRA_MS_2 + RND) / msm_pkg::SCAN_MS);
            default: extra_scans = 10'((msm_pkg::EXTRA_MS_3 + RND) / msm_pkg::SCAN_MS);
        endcase
    end

    msm_pair u_pair_a (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .sensor_pin({first_pair_sensor_two, first_pair_sensor_one}),
        .gap_scans(gap_scans),
        .conc_scans(conc_scans),
        .state(pair_a)
    );

    msm_pair u_pair_b (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .sensor_pin({second_pair_sensor_two, second_pair_sensor_one}),
        .gap_scans(gap_scans),
        .conc_scans(conc_scans),
        .state(pair_b)
    );

    assign first_p = first_is_b_q ? pair_b : pair_a;
    assign second_p = first_is_b_q ? pair_a : pair_b;
    assign timeout = state_q == ST_MUTE && total_s_q != 12'h000 && total_cnt_q >= total_scans;
    // a latched error blocks any new muting cycle until it is cleared
    assign mute_start = state_q == ST_READY && !error_q && aux_s && protective_switching_output_s && (pair_a.both || pair_b.both)
        && ((ctrl_q.dir == msm_pkg::MSM_DIR_FWD) ? pair_a.both : 1'b1)
        && ((ctrl_q.dir == msm_pkg::MSM_DIR_BWD) ? pair_b.both : 1'b1);

    // sequence: wait for the start condition, accept the first pair in the allowed
    // direction, mute until the end condition, then back to waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_WAIT_START;
            first_is_b_q <= 1'b0;
            second_seen_q <= 1'b0;
            last_is_b_q <= 1'b0;
        end else begin
            case (state_q)
                ST_WAIT_START: begin
                    if (protective_switching_output_s && (ctrl_q.start_last
                        ? !(last_is_b_q ? pair_a.any : pair_b.any)
                        : !(pair_a.any || pair_b.any))) begin
                        state_q <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (mute_start) begin
                        state_q <= ST_MUTE;
                        first_is_b_q <= !pair_a.both;
                        second_seen_q <= 1'b0;
                    end else if (ctrl_q.dir == msm_pkg::MSM_DIR_FWD && pair_b.any) begin
                        state_q <= ST_WAIT_START;
                    end else if (ctrl_q.dir == msm_pkg::MSM_DIR_BWD && pair_a.any) begin
                        state_q <= ST_WAIT_START;
                    end else if (!protective_switching_output_s) begin
                        state_q <= ST_WAIT_START;
                    end
                end
                ST_MUTE: begin
                    if (second_p.both) begin
                        second_seen_q <= 1'b1;
                    end
                    if (timeout || first_p.conc_err || second_p.conc_err) begin
                        state_q <= ST_ERROR;
                    end else if (pair_a.gap && pair_b.gap) begin
                        state_q <= ST_WAIT_START;
                        last_is_b_q <= !first_is_b_q;
                    end else if (!first_p.both && !second_p.both) begin
                        state_q <= ST_WAIT_START;
                        last_is_b_q <= first_is_b_q;
                    end else if (second_seen_q && ctrl_q.end_on_protective_switching_output && protective_switching_output_s && !first_p.both) begin
                        state_q <= ST_EXTRA;
                    end else if (second_seen_q && !ctrl_q.end_on_protective_switching_output && !second_p.both) begin
                        state_q <= ST_WAIT_START;
                        last_is_b_q <= !first_is_b_q;
                    end
                end
                ST_EXTRA: begin
                    if (first_p.conc_err || second_p.conc_err) begin
                        state_q <= ST_ERROR;
                    end else if (extra_cnt_q >= extra_scans) begin
                        state_q <= ST_WAIT_START;
                        last_is_b_q <= !first_is_b_q;
                    end
                end
                default: begin
                    if (clear_req && protective_switching_output_s) begin
                        state_q <= ST_WAIT_START;
                    end
                end
            endcase
        end
    end

    // total timer runs only while muting, frozen while the conveyor is stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_cnt_q <= 22'h000000;
        end else if (state_q != ST_MUTE && state_q != ST_EXTRA) begin
            total_cnt_q <= 22'h000000;
        end else if (tick && !conv_s && !timeout) begin
            total_cnt_q <= total_cnt_q + 22'h000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extra_cnt_q <= 10'h000;
        end else if (state_q != ST_EXTRA) begin
            extra_cnt_q <= 10'h000;
        end else if (tick) begin
            extra_cnt_q <= extra_cnt_q + 10'h001;
        end
    end

    // error latch: concurrency faults and timeouts hold until cleared with the curtain free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_q <= 1'b0;
            fault_q <= 1'b0;
        end else if (timeout) begin
            error_q <= 1'b1;
            fault_q <= 1'b1;
        end else if (pair_a.conc_err || pair_b.conc_err) begin
            error_q <= 1'b1;
        end else if (clear_req && protective_switching_output_s) begin
            error_q <= 1'b0;
            fault_q <= 1'b0;
        end
    end

    assign mute_end = (state_q == ST_MUTE || state_q == ST_EXTRA)
        && !(state_q == ST_MUTE && !timeout && !first_p.conc_err && !second_p.conc_err
        && !(pair_a.gap && pair_b.gap) && (first_p.both || second_p.both)
        && !(second_seen_q && !ctrl_q.end_on_protective_switching_output && !second_p.both))
        && !(state_q == ST_EXTRA && extra_cnt_q < extra_scans);

    // override keeps the outputs on only while sensors still see material
    assign muting_active = state_q == ST_MUTE || state_q == ST_EXTRA;
    assign override_active = ovr_s && (pair_a.any || pair_b.any) && !fault_q;
    assign output_enable = !error_q && (protective_switching_output_s || muting_active || override_active);
    assign muting_error = error_q;
    assign fault_present = fault_q;

endmodule

// *** msm_properties.sv ***
// assertions on the muting monitor outputs.
// assumes one pclk domain, presetn async active low.
`timescale 1ns/1ps
module msm_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic protective_switching_output,
    input wire logic muting_active,
    input wire logic override_active,
    input wire logic output_enable,
    input wire logic muting_error,
    input wire logic fault_present
);
    logic clr;
    assign clr = psel && penable && pwrite && paddr == msm_pkg::ADDR_CMD;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // four cycles covers the pin synchroniser
    sequence s_blocked;
        !protective_switching_output [*4] ##0 !muting_active && !override_active;
    endsequence
    a_err_drops_oe: assert property (muting_error |-> !output_enable)
        else $error("oe high in error");
    a_fault_has_err: assert property (fault_present |-> muting_error)
        else $error("fault without error");
    a_err_latched: assert property (muting_error && !clr |=> muting_error)
        else $error("error lost");
    a_fault_latched: assert property (fault_present && !clr |=> fault_present)
        else $error("fault lost");
    a_mute_opens_oe: assert property (muting_active && !muting_error |-> output_enable)
        else $error("oe low while muted");
    a_err_ends_mute: assert property (muting_error [*2] |-> !muting_active)
        else $error("muted in error");
    a_blocked_shuts: assert property (s_blocked |-> !output_enable)
        else $error("oe high when blocked");
    a_clear_opens: assert property (protective_switching_output [*4] ##0 !muting_error |-> output_enable)
        else $error("oe low when clear");
endmodule
bind msm_top msm_properties msm_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .protective_switching_output(protective_switching_output),
    .muting_active(muting_active), .override_active(override_active), .output_enable(output_enable),
    .muting_error(muting_error), .fault_present(fault_present));

// *** msm_field.sv ***
// model of the sensors and the curtain switching output.
// assumes the bench calls put from one process only.
`timescale 1ns/1ps
module msm_field (
    input wire logic pclk,
    output logic [3:0] sens = 4'h0,
    output logic curtain = 1'b1
);
    // durations are set above one scan, no test pulses, time limit kept
    task automatic put(input logic [3:0] s, input logic c, input int n);
        @(posedge pclk);
        sens <= s;
        curtain <= c;
        repeat (n) @(posedge pclk);
    endtask
endmodule

// *** msm_top_bench.sv ***
// bench of the muting monitor: apb tasks and field model calls.
// assumes a scan of 4 pclk cycles.
`timescale 1ns/1ps
module msm_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic conv = 1'b0;
    logic ovr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic [3:0] sens, first;
    logic se, pready, pslverr, curtain, mute, oe, err, fault, irq, ovra;
    int err_count = 0;
    int n_compared = 0;
    logic [39:0] defs [4] = '{40'h0000000074, 40'h0400000005, 40'h0c00000000, 40'h100000000a};
    always #2 pclk = ~pclk;
    msm_field msm_field_i (.pclk(pclk), .sens(sens), .curtain(curtain));
    msm_top #(.SCAN_CYCLES(4)) msm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_pair_sensor_one(sens[0]), .first_pair_sensor_two(sens[1]),
        .second_pair_sensor_one(sens[2]), .second_pair_sensor_two(sens[3]), .auxiliary_muting_signal(1'b0),
        .protective_switching_output(curtain), .override_in(ovr), .conveyor_stopped(conv),
        .muting_active(mute), .override_active(ovra), .output_enable(oe), .muting_error(err),
        .fault_present(fault), .irq(irq));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        se = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge lets a written register settle before the caller compares
        @(posedge pclk);
    endtask
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (defs[i]) begin
            apb(1'b0, defs[i][39:32], 32'h00000000);
            chk("reset value", defs[i][31:0], rd);
        end
        apb(1'b0, 8'h24, 32'h00000000);
        chk("unmapped", 32'h00000001, {31'h0, se});
        apb(1'b1, msm_pkg::ADDR_GAP, 32'h00000000);
        apb(1'b1, msm_pkg::ADDR_CONC, 32'h0000000a);
        for (int d = 1; d <= 2; d++) begin
            apb(1'b1, msm_pkg::ADDR_CTRL, {28'h0, 2'h1, d[1:0]});
            first = (d == 1) ? 4'h3 : 4'hc;
            msm_field_i.put(~first, 1'b1, 20);
            chk("wrong order", 32'h00000000, {31'h0, mute});
            msm_field_i.put(4'h0, 1'b1, 20);
            msm_field_i.put(first, 1'b1, 20);
            chk("right order", 32'h00000001, {31'h0, mute});
            msm_field_i.put(4'hf, 1'b0, 20);
            chk("muted oe", 32'h00000001, {31'h0, oe});
            msm_field_i.put(~first, 1'b1, 20);
            chk("last pair", 32'h00000001, {31'h0, mute});
            msm_field_i.put(4'h0, 1'b0, 20);
            chk("blocked oe", 32'h00000000, {31'h0, oe});
        end
        ovr <= 1'b1;
        apb(1'b1, msm_pkg::ADDR_CTRL, 32'h00000026);
        msm_field_i.put(4'h1, 1'b1, 420);
        chk("pair skew", 32'h00000001, {31'h0, err});
        chk("override", 32'h00000001, {31'h0, ovra});
        msm_field_i.put(4'h0, 1'b1, 10);
        apb(1'b1, msm_pkg::ADDR_CMD, 32'h00000001);
        apb(1'b1, msm_pkg::ADDR_CTRL, 32'h00000045);
        apb(1'b1, msm_pkg::ADDR_INT_MASK, 32'h00000008);
        msm_field_i.put(4'h3, 1'b1, 20);
        conv <= 1'b1;
        repeat (8000) @(posedge pclk);
        conv <= 1'b0;
        repeat (16000) @(posedge pclk);
        chk("held timer", 32'h00000000, {31'h0, err});
        repeat (6000) @(posedge pclk);
        chk("timeout", 32'h0000000c, {28'h0, err, fault, oe, ovra});
        chk("irq", 32'h00000001, {31'h0, irq});
        apb(1'b1, msm_pkg::ADDR_INT_MASK, 32'h00000000);
        chk("irq masked", 32'h00000000, {31'h0, irq});
        apb(1'b1, msm_pkg::ADDR_INT_MASK, 32'h00000008);
        apb(1'b1, msm_pkg::ADDR_INT_STAT, 32'h00000008);
        chk("irq cleared", 32'h00000000, {31'h0, irq});
        give_verdict();
    end
endmodule
